// ===== logic/drc_pkg.sv
/*
 Constants, field layout and state types shared by the refresh controller and its interval timer.
 Assumes a CPU core on the same clock that gives bus, sleep and wait status and machine-cycle ends.
*/
package drc_pkg;
	// I/O-mapped control register
	localparam logic [7:0] DRC_RCR_ADDR = 8'h36;
	localparam int DRC_ON_BIT = 7;
	localparam int DRC_WAIT_BIT = 6;
	localparam int DRC_IVH_BIT = 1;
	localparam int DRC_IVL_BIT = 0;
	localparam logic DRC_ON_RST = 1'b1;
	localparam logic DRC_WAIT_RST = 1'b1;
	localparam logic [1:0] DRC_IV_RST = 2'h0;
	localparam logic [7:0] DRC_ZERO8 = 8'h00;
	// Interval selections and their lengths in clock states
	localparam logic [1:0] DRC_SEL_10 = 2'h0;
	localparam logic [1:0] DRC_SEL_20 = 2'h1;
	localparam logic [1:0] DRC_SEL_40 = 2'h2;
	localparam logic [1:0] DRC_SEL_80 = 2'h3;
	localparam int DRC_CNT_W = 7;
	localparam logic [DRC_CNT_W-1:0] DRC_IV_10 = 7'h0a;
	localparam logic [DRC_CNT_W-1:0] DRC_IV_20 = 7'h14;
	localparam logic [DRC_CNT_W-1:0] DRC_IV_40 = 7'h28;
	localparam logic [DRC_CNT_W-1:0] DRC_IV_80 = 7'h50;
	localparam logic [DRC_CNT_W-1:0] DRC_CNT_ONE = 7'h01;
	localparam logic [DRC_CNT_W-1:0] DRC_CNT_RST = 7'h00;
	// Refresh address
	localparam int DRC_ADDR_W = 8;
	localparam logic [DRC_ADDR_W-1:0] DRC_ADDR_RST = 8'h00;
	localparam logic [DRC_ADDR_W-1:0] DRC_ADDR_STEP = 8'h01;

	typedef enum logic [1:0] {DRC_IDLE, DRC_T1, DRC_T2, DRC_TW} drc_phase_type;
endpackage : drc_pkg

// ===== logic/drc_tmr_if.sv
/*
 Carrier between the refresh controller and its interval timer.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface drc_tmr_if;
	logic [1:0] sel;
	logic tick;
	modport ctrl (output sel, input tick);
	modport tmr (input sel, output tick);
endinterface : drc_tmr_if

// ===== logic/drc_interval_timer.sv
/*
 Free-running refresh interval timer; one tick per selected number of clock states.
 Assumes every mclk edge is one CPU clock state.
*/
`timescale 1ns/100ps
module drc_interval_timer import drc_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Interval select in, tick out
	drc_tmr_if.tmr tif
);
	typedef struct packed {
		logic [DRC_CNT_W-1:0] cnt;
		logic tick;
	} drc_tmr_state_type;

	drc_tmr_state_type s_r;
	drc_tmr_state_type s_nxt;
	logic [DRC_CNT_W-1:0] lim;

	// Interval length from the select
	always_comb begin
		unique case (tif.sel)
			DRC_SEL_10: lim = DRC_IV_10;
			DRC_SEL_20: lim = DRC_IV_20;
			DRC_SEL_40: lim = DRC_IV_40;
			DRC_SEL_80: lim = DRC_IV_80;
		endcase
	end

	// Count every state; >= so a shorter new select never overruns
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (s_r.cnt >= lim - DRC_CNT_ONE) begin
			s_nxt.cnt = DRC_CNT_RST;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = DRC_CNT_W'(s_r.cnt + DRC_CNT_ONE);
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tif.tick = s_r.tick;

	AST_TICK_SPACING: assert property (@(posedge mclk) disable iff (rst)
		tif.tick |=> !tif.tick [*8]) else $error("Refresh ticks closer than minimum interval");
	// Checker helper: states since the last tick, counted only while the ten-state select holds
	logic [DRC_CNT_W-1:0] chk_run_r;
	always_ff @(posedge mclk) begin
		if (rst) begin
			chk_run_r <= DRC_CNT_RST;
		end else if (tif.tick) begin
			chk_run_r <= (tif.sel == DRC_SEL_10) ? DRC_CNT_ONE : DRC_CNT_RST;
		end else if (tif.sel == DRC_SEL_10 && chk_run_r != DRC_CNT_RST) begin
			chk_run_r <= DRC_CNT_W'(chk_run_r + DRC_CNT_ONE);
		end else begin
			chk_run_r <= DRC_CNT_RST;
		end
	end

	AST_PERIOD_10: assert property (@(posedge mclk) disable iff (rst)
		chk_run_r == DRC_IV_10 |-> tif.tick)
		else $error("Ten-state interval not kept");
endmodule : drc_interval_timer

// ===== logic/drc_refresh_ctrl.sv
/*
 DRAM refresh controller: control register, request latch, refresh bus cycle sequencer, address counter.
 Assumes the CPU core marks machine-cycle ends and reports bus grant, sleep and wait on the same clock,
 and stretches its own cycle while refresh_cycle is high.
*/
`timescale 1ns/100ps
module drc_refresh_ctrl import drc_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// CPU internal I/O port
	input wire logic [7:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	// CPU status
	input wire logic bus_granted,
	input wire logic sleep_mode,
	input wire logic wait_active,
	input wire logic mcycle_end,
	// Refresh bus cycle
	output logic refresh_cycle,
	output logic refresh_wait_state,
	output logic refresh_done,
	output logic [DRC_ADDR_W-1:0] refresh_addr
);
	// All controller state; one copy is computed, one is registered
	typedef struct packed {
		drc_phase_type phase;
		logic on;
		logic xwait;
		logic [1:0] iv;
		logic pending;
		logic [DRC_ADDR_W-1:0] addr;
		logic [7:0] rdata;
		logic cyc;
		logic tw;
		logic done;
	} drc_state_type;

	drc_state_type s_r;
	drc_state_type s_nxt;
	logic allow;
	logic start;
	logic [7:0] ctrl_view;

	// Interval timer runs on every state, whatever the bus, sleep or enable state
	drc_tmr_if tif ();

	drc_interval_timer u_timer (
		.mclk(mclk),
		.rst(rst),
		.tif(tif)
	);

	// Select goes straight from the register; the timer never restarts on a change,
	// so software sees at most one short interval after switching
	assign tif.sel = s_r.iv;

	// Register image; unused bits read zero
	always_comb begin
		ctrl_view = DRC_ZERO8;
		ctrl_view[DRC_ON_BIT] = s_r.on;
		ctrl_view[DRC_WAIT_BIT] = s_r.xwait;
		ctrl_view[DRC_IVH_BIT] = s_r.iv[1];
		ctrl_view[DRC_IVL_BIT] = s_r.iv[0];
	end

	// Insertion only at a machine-cycle end with the bus ours and the CPU awake and unstalled
	// Enable is folded in too, so a request caught just before a disable never starts
	assign allow = mcycle_end && !bus_granted && !sleep_mode && !wait_active && s_r.on;
	assign start = (s_r.phase == DRC_IDLE) && s_r.pending && allow;

	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.rdata = (io_rd && io_addr == DRC_RCR_ADDR) ? ctrl_view : DRC_ZERO8;
		// Request latch: a fresh tick beats the consume of the old one
		if (start) begin
			s_nxt.pending = 1'b0;
		end
		if (tif.tick && s_r.on) begin
			s_nxt.pending = 1'b1;
		end
		// Granted bus drops requests; the timer keeps running meanwhile
		if (bus_granted || !s_r.on) begin
			s_nxt.pending = 1'b0;
		end
		// Refresh cycle sequencer
		// Every cycle returns to idle, so one idle state always separates two refresh cycles
		unique case (s_r.phase)
			DRC_IDLE: begin
				if (start) begin
					s_nxt.phase = DRC_T1;
					s_nxt.cyc = 1'b1;
				end
			end
			DRC_T1: begin
				s_nxt.phase = DRC_T2;
			end
			DRC_T2: begin
				if (s_r.xwait) begin
					s_nxt.phase = DRC_TW;
					s_nxt.tw = 1'b1;
				end else begin
					s_nxt.phase = DRC_IDLE;
					s_nxt.cyc = 1'b0;
					s_nxt.addr = DRC_ADDR_W'(s_r.addr + DRC_ADDR_STEP);
					s_nxt.done = 1'b1;
				end
			end
			DRC_TW: begin
				s_nxt.phase = DRC_IDLE;
				s_nxt.cyc = 1'b0;
				s_nxt.tw = 1'b0;
				s_nxt.addr = DRC_ADDR_W'(s_r.addr + DRC_ADDR_STEP);
				s_nxt.done = 1'b1;
			end
		endcase
		// Software write; a length change mid-cycle takes effect at T2
		if (io_wr && io_addr == DRC_RCR_ADDR) begin
			s_nxt.on = io_wdata[DRC_ON_BIT];
			s_nxt.xwait = io_wdata[DRC_WAIT_BIT];
			s_nxt.iv = {io_wdata[DRC_IVH_BIT], io_wdata[DRC_IVL_BIT]};
		end
	end

	// State register; reset holds off all insertion
	always_ff @(posedge mclk) begin
		if (rst) begin
			s_r <= '0;
			s_r.phase <= DRC_IDLE;
			s_r.on <= DRC_ON_RST;
			s_r.xwait <= DRC_WAIT_RST;
			s_r.iv <= DRC_IV_RST;
			s_r.addr <= DRC_ADDR_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign io_rdata = s_r.rdata;
	assign refresh_cycle = s_r.cyc;
	assign refresh_wait_state = s_r.tw;
	assign refresh_done = s_r.done;
	assign refresh_addr = s_r.addr;

	// Checks; seq_begin names the step that several properties share, seq_ready the condition AST_WAKE_RUN uses
	sequence seq_begin;
		$rose(refresh_cycle);
	endsequence
	sequence seq_ready;
		s_r.pending && s_r.phase == DRC_IDLE && mcycle_end && !sleep_mode && !bus_granted && !wait_active && s_r.on;
	endsequence

	// Reset, start, cycle length, address and request latch conditions
	AST_RESET_VALUES: assert property (@(posedge mclk)
		$past(rst) && !rst |-> (s_r.on && s_r.xwait && s_r.iv == DRC_IV_RST && !refresh_cycle
		&& refresh_addr == DRC_ADDR_RST && io_rdata == DRC_ZERO8))
		else $error("Control register reset values wrong");
	AST_NO_STALLED_START: assert property (@(posedge mclk) disable iff (rst)
		bus_granted || sleep_mode || wait_active |=> !$rose(refresh_cycle)) else $error("Refresh started while stalled");
	AST_NO_BLOCKED_START: assert property (@(posedge mclk) disable iff (rst)
		seq_begin |-> $past(mcycle_end && !bus_granted && !sleep_mode && !wait_active))
		else $error("Refresh started while blocked");
	AST_DISABLED: assert property (@(posedge mclk) disable iff (rst)
		seq_begin |-> $past(s_r.on)) else $error("Refresh started while disabled");
	AST_LEN_THREE: assert property (@(posedge mclk) disable iff (rst)
		(seq_begin ##0 s_r.xwait) ##1 s_r.xwait |-> refresh_cycle [*2] ##1 !refresh_cycle)
		else $error("Three-clock refresh cycle length wrong");
	AST_LEN_TWO: assert property (@(posedge mclk) disable iff (rst)
		(seq_begin ##0 !s_r.xwait) ##1 !s_r.xwait |-> refresh_cycle ##1 !refresh_cycle)
		else $error("Two-clock refresh cycle length wrong");
	AST_ADDR_STEP: assert property (@(posedge mclk) disable iff (rst)
		$fell(refresh_cycle) |-> refresh_addr == $past(refresh_addr) + DRC_ADDR_STEP && refresh_done)
		else $error("Refresh address did not advance after cycle");
	AST_ADDR_HOLD: assert property (@(posedge mclk) disable iff (rst)
		!$fell(refresh_cycle) |-> $stable(refresh_addr)) else $error("Refresh address moved without a cycle");
	AST_SLEEP_LATCH: assert property (@(posedge mclk) disable iff (rst)
		tif.tick && sleep_mode && s_r.on && !bus_granted |=> s_r.pending)
		else $error("Request during sleep not latched");
	AST_GRANT_DROP: assert property (@(posedge mclk) disable iff (rst)
		bus_granted |=> !s_r.pending) else $error("Request kept while bus granted");
	AST_WAKE_RUN: assert property (@(posedge mclk) disable iff (rst)
		seq_ready |=> seq_begin) else $error("Held refresh not run at cycle end");

	// Register port: one-cycle read image, and writes that land at the next edge
	sequence seq_rcr_read;
		io_rd && io_addr == DRC_RCR_ADDR;
	endsequence
	sequence seq_rcr_write;
		io_wr && io_addr == DRC_RCR_ADDR;
	endsequence

	AST_READ_IMAGE: assert property (@(posedge mclk) disable iff (rst)
		seq_rcr_read |=> io_rdata[DRC_ON_BIT] == $past(s_r.on) && io_rdata[DRC_WAIT_BIT] == $past(s_r.xwait)
		&& io_rdata[DRC_IVH_BIT] == $past(s_r.iv[1]) && io_rdata[DRC_IVL_BIT] == $past(s_r.iv[0]))
		else $error("Control register read image wrong");
	AST_WRITE_TAKES: assert property (@(posedge mclk) disable iff (rst)
		seq_rcr_write |=> s_r.on == $past(io_wdata[DRC_ON_BIT]) && s_r.xwait == $past(io_wdata[DRC_WAIT_BIT])
		&& s_r.iv == {$past(io_wdata[DRC_IVH_BIT]), $past(io_wdata[DRC_IVL_BIT])})
		else $error("Control register write did not land");

	// Cycle shape: the added wait state is always the third state, done is a single pulse
	AST_WAIT_THIRD: assert property (@(posedge mclk) disable iff (rst)
		refresh_wait_state |-> refresh_cycle && $past(refresh_cycle) && $past(refresh_cycle, 2)
		&& !$past(refresh_cycle, 3)) else $error("Refresh wait state not in the third state");
	AST_DONE_PULSE: assert property (@(posedge mclk) disable iff (rst)
		refresh_done |=> !refresh_done) else $error("Refresh done longer than one cycle");

	// Request latch: ticks are caught, held across sleep and wait, and lost while disabled
	AST_TICK_LATCH: assert property (@(posedge mclk) disable iff (rst)
		tif.tick && s_r.on && !bus_granted |=> s_r.pending)
		else $error("Interval tick not latched as a request");
	AST_HOLD_PENDING: assert property (@(posedge mclk) disable iff (rst)
		s_r.pending && (sleep_mode || wait_active) && !bus_granted && s_r.on |=> s_r.pending)
		else $error("Held request lost during sleep or wait");
	AST_DISABLED_DROP: assert property (@(posedge mclk) disable iff (rst)
		!s_r.on |=> !s_r.pending) else $error("Request kept while refresh disabled");
endmodule : drc_refresh_ctrl

// ===== tb/drc_dram_model.sv
/*
 Dynamic RAM array model that watches refresh bus cycles and times them.
 Assumes the refresh signals come from the controller on mclk.
*/
`timescale 1ns/100ps
module drc_dram_model import drc_pkg::*; (
	// Clock
	input wire logic mclk,
	// Refresh bus cycle
	input wire logic refresh_cycle,
	input wire logic refresh_wait_state,
	input wire logic refresh_done,
	input wire logic [DRC_ADDR_W-1:0] refresh_addr
);
	int cyc = 0;
	int t_last = 0;
	int gap = 0;
	int run = 0;
	int len = 0;
	int wpos = 0;
	int wlast = 0;
	int n_done = 0;
	logic prev = 1'b0;
	logic [DRC_ADDR_W-1:0] last_row = '0;
	// Start spacing, length and wait position of each refresh the array sees
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		prev <= refresh_cycle;
		if (refresh_cycle && !prev) begin
			gap <= cyc - t_last;
			t_last <= cyc;
		end
		if (refresh_cycle) begin
			run <= (prev ? run : 0) + 1;
			last_row <= refresh_addr;
		end
		if (refresh_wait_state)
			wpos <= run + 1;
		if (refresh_done) begin
			len <= run;
			wlast <= wpos;
			wpos <= 0;
			n_done <= n_done + 1;
		end
	end
endmodule : drc_dram_model

// ===== tb/drc_refresh_ctrl_test.sv
/*
 Self-checking bench for the refresh controller: register access, intervals, suppression.
 Assumes the design package and the array model are compiled first.
*/
`timescale 1ns/100ps
module drc_refresh_ctrl_test import drc_pkg::*;;
	`define DM u_drc_dram_model
	`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
		$display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] io_addr = 8'h00;
	logic io_wr = 1'b0;
	logic io_rd = 1'b0;
	logic [7:0] io_wdata = 8'h00;
	logic [7:0] io_rdata;
	logic bus_granted = 1'b0;
	logic sleep_mode = 1'b0;
	logic wait_active = 1'b0;
	logic mcycle_end = 1'b0;
	logic refresh_cycle;
	logic refresh_wait_state;
	logic refresh_done;
	logic [DRC_ADDR_W-1:0] refresh_addr;
	logic [7:0] q;
	int err_count = 0;
	int num_checks = 0;
	int n0;
	int t0;

	drc_refresh_ctrl u_drc_refresh_ctrl (.mclk, .rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
		.bus_granted, .sleep_mode, .wait_active, .mcycle_end, .refresh_cycle, .refresh_wait_state,
		.refresh_done, .refresh_addr);
	drc_dram_model u_drc_dram_model (.mclk, .refresh_cycle, .refresh_wait_state, .refresh_done,
		.refresh_addr);

	// Clock, 4 ns period
	initial forever #2 mclk = ~mclk;

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge mclk);
		io_wr = 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(negedge mclk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge mclk);
		io_rd = 1'b0;
		q = io_rdata;
	endtask : rd

	// Bounded wait; running out of time counts as a mismatch
	task wait_done(input int n);
		int k;
		k = `DM.n_done + n;
		for (int i = 0; i < 2000 && `DM.n_done < k; i++)
			@(negedge mclk);
		`CHK(`DM.n_done >= k, 1'b1)
	endtask : wait_done

	task hold(input int n);
		n0 = `DM.n_done;
		repeat (n) @(negedge mclk);
		`CHK(`DM.n_done, n0)
	endtask : hold

	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	// Main sequence
	initial begin
		repeat (6) @(negedge mclk);
		`CHK(`DM.n_done, 0)
		rst = 1'b0;
		rd(DRC_RCR_ADDR);
		`CHK(q, 8'hC0)
		rd(8'h38);
		`CHK(q, 8'h00)
		wr(8'h38, 8'h3F);
		rd(DRC_RCR_ADDR);
		`CHK(q, 8'hC0)
		mcycle_end = 1'b1;
		wait_done(3);
		`CHK(`DM.gap, 10)
		`CHK(`DM.wlast, 3)
		$display("test reset done");
		for (int s = 0; s < 4; s++) begin
			wr(DRC_RCR_ADDR, 8'hBC | 8'(s));
			rd(DRC_RCR_ADDR);
			`CHK(q, 8'h80 | 8'(s))
			wait_done(3);
			`CHK(`DM.gap, 10 << s)
			`CHK(`DM.len * 10 + `DM.wlast, 20)
		end
		$display("test interval done");
		wr(DRC_RCR_ADDR, 8'h00);
		repeat (10) @(negedge mclk);
		hold(200);
		// Shortest interval keeps the array inside its refresh budget
		wr(DRC_RCR_ADDR, 8'h80);
		wait_done(1);
		$display("test disable done");
		// Grant span is off the interval grid, so a timer that paused would show in the gap
		bus_granted = 1'b1;
		hold(63);
		bus_granted = 1'b0;
		wait_done(1);
		`CHK(`DM.gap % 10, 0)
		$display("test grant done");
		t0 = `DM.t_last;
		sleep_mode = 1'b1;
		mcycle_end = 1'b0;
		hold(55);
		sleep_mode = 1'b0;
		repeat (3) @(negedge mclk);
		`CHK(refresh_cycle, 1'b0)
		mcycle_end = 1'b1;
		@(negedge mclk);
		`CHK(refresh_cycle, 1'b1)
		wait_done(2);
		`CHK((`DM.t_last - t0) % 10, 0)
		$display("test sleep done");
		wait_active = 1'b1;
		hold(60);
		wait_active = 1'b0;
		wait_done(1);
		`CHK(refresh_addr, 8'(`DM.n_done))
		`CHK(`DM.last_row, 8'(`DM.n_done - 1))
		$display("test wait done");
		complete_run();
	end

	// Watchdog, well past the thousand or so cycles the tests need
	initial begin
		#60000;
		err_count++;
		complete_run();
	end
endmodule : drc_refresh_ctrl_test
